//--- sps_regs.svh
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH
`define SPS_CLK_MHZ 100
`define SPS_BUS_CLEAR_NS 800
`define SPS_BUS_CLEAR_CYC ((`SPS_BUS_CLEAR_NS * `SPS_CLK_MHZ) / 1000)
`define SPS_BUS_SETTLE_NS 400
`define SPS_BUS_SETTLE_CYC \
  ((`SPS_BUS_SETTLE_NS * `SPS_CLK_MHZ + 999) / 1000)
`define SPS_ATN_POLL_US 1000
`define SPS_ATN_POLL_CYC (`SPS_ATN_POLL_US * `SPS_CLK_MHZ)
`define SPS_READY_S 15
`define SPS_READY_CYC (`SPS_READY_S * `SPS_CLK_MHZ * 1000000)
`define SPS_MODE_DEFAULT 8'h00
`define SPS_MSG_RESTORE_PTRS 8'h03
`define SPS_MSG_SAVE_DPTR 8'h02
`define SPS_MSG_EXTENDED 8'h01
`define SPS_MSG_TWO_LO 8'h20
`define SPS_MSG_TWO_HI 8'h2f
`endif

//--- sps_pkg.sv
package sps_pkg;
  // Phase code {msg, cd, io}
  typedef enum logic [2:0] {
    SPS_PH_DATA_OUT = 3'h0,
    SPS_PH_DATA_IN = 3'h1,
    SPS_PH_COMMAND = 3'h2,
    SPS_PH_STATUS = 3'h3,
    SPS_PH_MSG_OUT = 3'h6,
    SPS_PH_MSG_IN = 3'h7
  } sps_phase_t;
endpackage

//--- sps_bus_if.sv
`timescale 1ns/1ps
interface sps_bus_if;
  logic bsy_i;
  logic bsy_o;
  logic sel_i;
  logic msg;
  logic cd;
  logic io;
  logic req;
  logic ack;
  logic atn;
  logic [7:0] db_i;
  logic [7:0] db_t;
  logic [7:0] db_oe;
  logic rst_i;
  modport target (
    input bsy_i,
    output bsy_o,
    input sel_i,
    input rst_i,
    output msg,
    output cd,
    output io,
    output req,
    input ack,
    input atn,
    input db_i,
    output db_t,
    output db_oe
  );
  modport initiator (
    input bsy_o,
    output bsy_i,
    output sel_i,
    output rst_i,
    input msg,
    input cd,
    input io,
    input req,
    output ack,
    output atn,
    output db_i,
    input db_t,
    input db_oe
  );
endinterface

//--- sps_initiator.sv
`timescale 1ns/1ps
`include "sps_regs.svh"
module sps_initiator
  import sps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  sps_bus_if.initiator bus,
  input wire logic start,
  input wire logic [7:0] tx_byte,
  input wire logic want_atn,
  input wire logic bus_reset,
  input wire logic [31:0] cmd_base,
  input wire logic [31:0] data_base,
  input wire logic [31:0] stat_base,
  output logic busy,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic [2:0] rx_phase,
  output logic [31:0] act_data_ptr,
  output logic [31:0] sav_data_ptr
);
  typedef enum logic [3:0] {
    SPSI_IDLE = 4'h1,
    SPSI_SEL = 4'h2,
    SPSI_XFER = 4'h4,
    SPSI_ACKH = 4'h8
  } sps_ist_t;
  typedef struct packed {
    sps_ist_t st;
    logic [15:0] free_cnt;
    logic sel;
    logic ack;
    logic atn;
    logic rst;
    logic [7:0] db;
    logic db_en;
    logic busy;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic [2:0] rx_phase;
    logic [31:0] act_cmd;
    logic [31:0] act_data;
    logic [31:0] act_stat;
    logic [31:0] sav_cmd;
    logic [31:0] sav_data;
    logic [31:0] sav_stat;
  } sps_ireg_t;
  sps_ireg_t r;
  sps_ireg_t next_r;
  logic [2:0] ph;

  assign ph = {bus.msg, bus.cd, bus.io};
  assign bus.sel_i = r.sel;
  assign bus.ack = r.ack;
  assign bus.atn = r.atn;
  assign bus.rst_i = r.rst; // [R14]
  assign bus.bsy_i = r.sel;
  assign bus.db_i = r.db_en ? r.db : 8'h00;
  assign busy = r.busy;
  assign rx_valid = r.rx_valid;
  assign rx_byte = r.rx_byte;
  assign rx_phase = r.rx_phase;
  assign act_data_ptr = r.act_data;
  assign sav_data_ptr = r.sav_data;

  always_comb
  begin
    next_r = r;
    next_r.rx_valid = 1'b0;
    next_r.rst = bus_reset;
    if (want_atn)
      next_r.atn = 1'b1; // [R7]
    if (!bus.bsy_o && !r.sel)
    begin
      if (r.free_cnt < 16'(`SPS_BUS_SETTLE_CYC))
        next_r.free_cnt = r.free_cnt + 16'h1; // [R17]
    end
    else
      next_r.free_cnt = 16'h0;
    case (r.st)
      SPSI_IDLE:
      begin
        next_r.busy = 1'b0;
        if (start && r.free_cnt >= 16'(`SPS_BUS_SETTLE_CYC)) // [R16]
        begin
          next_r.sel = 1'b1;
          next_r.busy = 1'b1;
          next_r.act_cmd = cmd_base; // [R19]
          next_r.act_data = data_base;
          next_r.act_stat = stat_base;
          next_r.sav_cmd = cmd_base;
          next_r.sav_data = data_base;
          next_r.sav_stat = stat_base;
          next_r.st = SPSI_SEL;
        end
      end
      SPSI_SEL:
        if (bus.bsy_o)
        begin
          next_r.sel = 1'b0;
          next_r.st = SPSI_XFER;
        end
      SPSI_XFER:
        if (!bus.bsy_o)
        begin
          // Disconnect puts only the saved data pointer back as active
          next_r.act_data = r.sav_data; // [R21]
          next_r.st = SPSI_IDLE;
        end
        else if (bus.req)
        begin
          next_r.rx_phase = ph;
          if (ph[0])
          begin
            next_r.rx_byte = bus.db_t;
            next_r.rx_valid = 1'b1;
            if (ph == 3'h7 && bus.db_t == `SPS_MSG_SAVE_DPTR)
              next_r.sav_data = r.act_data; // [R20]
            if (ph == 3'h7 && bus.db_t == `SPS_MSG_RESTORE_PTRS)
            begin
              next_r.act_cmd = r.sav_cmd; // [R21]
              next_r.act_data = r.sav_data;
              next_r.act_stat = r.sav_stat;
            end
          end
          else
          begin
            next_r.db = tx_byte;
            next_r.db_en = 1'b1;
            // A fresh request in the same cycle wins over the clear
            if (ph == 3'h6 && !want_atn)
              next_r.atn = 1'b0;
          end
          if (ph[2:1] == 2'b00)
            next_r.act_data = r.act_data + 32'h1;
          next_r.ack = 1'b1;
          next_r.st = SPSI_ACKH;
        end
      SPSI_ACKH:
        if (!bus.req)
        begin
          next_r.ack = 1'b0;
          next_r.db_en = 1'b0;
          next_r.st = SPSI_XFER;
        end
      default:
        next_r.st = SPSI_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.st <= SPSI_IDLE;
    end
    else
      r <= next_r;
  end
endmodule

//--- sps_target.sv
`timescale 1ns/1ps
`include "sps_regs.svh"
// Functional notes
// [R1] Data In: I/O true, C/D MSG false
// [R2] Data Out: all three phase lines false
// [R3] Status: C/D and I/O true, MSG false
// [R4] Status once per command; errors go free
// [R5] Hold status until write is durable
// [R6] Messages never straddle two message phases
// [R7] Attention before last ack enters Message Out
// [R8] Data phase polls attention every millisecond
// [R9] Reset releases bus within clear delay
// [R10] Reset always returns to Bus Free
// [R11] Reset drops processes and reservations
// [R12] Reset restores modes to saved defaults
// [R13] Reset sets pending unit attention
// [R14] Target never drives bus reset
// [R15] Finish current block before reset actions
// [R16] Free, selection, then transfer phases
// [R17] Free after settle delay of idle lines
// [R18] Ready for basic commands within 15 s
// [R19] Initiator keeps three saved pointers
// [R20] Save data pointer copies active to saved
// [R21] Restore or reconnect copies saved to active; code restores only data pointer at disconnect, start reloads bases
// [R22] Target never sends restore pointers
// [R23] Target drives phase lines: encodings
// [R24] Bus delays counted in clock cycles
module sps_target
  import sps_pkg::*;
#(
  parameter int READY_CYC = `SPS_READY_CYC,
  parameter int POLL_CYC = `SPS_ATN_POLL_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  sps_bus_if.target bus,
  input wire logic [2:0] req_phase,
  input wire logic req_valid,
  input wire logic [7:0] tx_byte,
  input wire logic req_last,
  input wire logic write_durable,
  input wire logic block_busy,
  input wire logic error,
  input wire logic [7:0] mode_saved,
  input wire logic mode_saved_valid,
  output logic req_ready,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic [2:0] cur_phase,
  output logic atn_seen,
  output logic connected,
  output logic unit_attention,
  output logic reserved,
  output logic io_pending,
  output logic [7:0] mode,
  output logic ready
);
  typedef enum logic [6:0] {
    SPST_FREE = 7'h01,
    SPST_WAIT_SEL = 7'h02,
    SPST_CONN = 7'h04,
    SPST_REQ = 7'h08,
    SPST_ACK_LO = 7'h10,
    SPST_RST = 7'h20,
    SPST_CLEAR = 7'h40
  } sps_tst_t;
  typedef struct packed {
    sps_tst_t st;
    logic [15:0] cnt;
    logic [31:0] poll;
    logic [31:0] boot;
    logic bsy;
    logic req;
    logic [2:0] phase;
    logic [7:0] db;
    logic db_en;
    logic status_done;
    logic msg_open;
    logic last;
    logic req_ready;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic atn_seen;
    logic ua;
    logic resv;
    logic iop;
    logic [7:0] mode;
    logic ready;
  } sps_treg_t;
  sps_treg_t r;
  sps_treg_t next_r;

  // Phase code legality; checked for every offered request, refused ones included
  function automatic logic legal_phase(input logic [2:0] p, input logic sd);
    legal_phase = (p != 3'h4) && (p != 3'h5) &&
      !(p == SPS_PH_STATUS && sd); // [R4]
  endfunction

  assign bus.bsy_o = r.bsy; // No reset driver here [R14]
  assign {bus.msg, bus.cd, bus.io} = r.bsy ? r.phase : 3'h0; // [R23]
  assign bus.req = r.req;
  assign bus.db_t = r.db_en ? r.db : 8'h00; // Released lines read false
  assign bus.db_oe = {8{~r.db_en}};
  assign req_ready = r.req_ready;
  assign rx_valid = r.rx_valid;
  assign rx_byte = r.rx_byte;
  assign cur_phase = r.phase;
  assign atn_seen = r.atn_seen;
  assign connected = r.bsy;
  assign unit_attention = r.ua;
  assign reserved = r.resv;
  assign io_pending = r.iop;
  assign mode = r.mode;
  assign ready = r.ready;

  always_comb
  begin
    next_r = r;
    next_r.rx_valid = 1'b0;
    next_r.req_ready = 1'b0;
    if (r.boot < READY_CYC)
      next_r.boot = r.boot + 32'h1;
    else
      next_r.ready = 1'b1; // [R18]
    if (r.phase[2:1] == 2'b00 && r.bsy)
    begin
      if (r.poll >= POLL_CYC - 1)
      begin
        next_r.poll = 32'h0;
        if (bus.atn)
          next_r.atn_seen = 1'b1; // [R8]
      end
      else
        next_r.poll = r.poll + 32'h1;
    end
    else
      next_r.poll = 32'h0;
    if (bus.rst_i && r.st != SPST_RST && r.st != SPST_CLEAR)
    begin
      next_r.st = SPST_RST; // [R9]
      next_r.bsy = 1'b0;
      next_r.req = 1'b0;
      next_r.db_en = 1'b0;
      next_r.phase = SPS_PH_DATA_OUT;
      next_r.cnt = 16'h0;
    end
    else
      case (r.st)
        SPST_FREE:
        begin
          if (bus.bsy_i || bus.sel_i)
            next_r.cnt = 16'h0;
          else if (r.cnt < 16'(`SPS_BUS_SETTLE_CYC))
            next_r.cnt = r.cnt + 16'h1; // [R24]
          if (r.cnt >= 16'(`SPS_BUS_SETTLE_CYC)) // [R17]
            next_r.st = SPST_WAIT_SEL;
        end
        SPST_WAIT_SEL:
          if (bus.sel_i) // [R16]
          begin
            next_r.bsy = 1'b1;
            next_r.status_done = 1'b0;
            next_r.msg_open = 1'b0;
            next_r.iop = 1'b1;
            next_r.atn_seen = bus.atn;
            next_r.st = SPST_CONN;
          end
          else if (bus.bsy_i)
            next_r.st = SPST_FREE;
        SPST_CONN:
          if (error)
          begin
            next_r.bsy = 1'b0; // [R4]
            next_r.iop = 1'b0;
            next_r.cnt = 16'h0;
            next_r.st = SPST_FREE;
          end
          else if ((r.atn_seen || bus.atn) && !r.msg_open) // [R7]
          begin
            next_r.phase = SPS_PH_MSG_OUT;
            next_r.atn_seen = 1'b0;
            next_r.st = SPST_REQ;
          end
          else if (req_valid && legal_phase(req_phase, r.status_done) &&
                   !(req_phase == SPS_PH_STATUS && !write_durable) && // [R5]
                   !(req_phase == SPS_PH_MSG_IN &&
                     tx_byte == `SPS_MSG_RESTORE_PTRS && !r.msg_open))
          begin
            // Restore-pointers code is withheld outside an open message; host restores itself
            next_r.phase = req_phase; // [R22]
            next_r.req_ready = 1'b1;
            next_r.last = req_last;
            next_r.db = tx_byte;
            next_r.db_en = req_phase[0]; // [R1] [R3]
            if (req_phase == SPS_PH_STATUS)
              next_r.status_done = 1'b1; // [R4]
            next_r.st = SPST_REQ;
          end
          else if (!req_valid && r.status_done && !r.msg_open &&
                   r.phase == SPS_PH_MSG_IN)
          begin
            next_r.bsy = 1'b0;
            next_r.iop = 1'b0;
            next_r.ua = 1'b0; // Reported with this status [R13]
            next_r.cnt = 16'h0;
            next_r.st = SPST_FREE;
          end
        SPST_REQ:
        begin
          next_r.req = 1'b1; // [R2]
          if (r.req && bus.ack)
          begin
            if (!r.phase[0])
            begin
              next_r.rx_byte = bus.db_i;
              next_r.rx_valid = 1'b1;
            end
            if (bus.atn && r.last && r.phase != SPS_PH_MSG_OUT)
              next_r.atn_seen = 1'b1; // [R7]
            if (r.phase[2])
              next_r.msg_open = (r.phase == SPS_PH_MSG_OUT) ? bus.atn :
                !r.last; // [R6]
            next_r.req = 1'b0;
            next_r.st = SPST_ACK_LO;
          end
        end
        SPST_ACK_LO:
          if (!bus.ack)
          begin
            next_r.db_en = 1'b0;
            next_r.st = SPST_CONN;
          end
        SPST_RST:
        begin
          if (r.cnt < 16'(`SPS_BUS_CLEAR_CYC))
            next_r.cnt = r.cnt + 16'h1;
          if (!block_busy) // [R15]
          begin
            next_r.iop = 1'b0; // [R11]
            next_r.resv = 1'b0;
            next_r.mode = mode_saved_valid ? mode_saved :
              `SPS_MODE_DEFAULT; // [R12]
            next_r.ua = 1'b1; // [R13]
            next_r.st = SPST_CLEAR;
          end
        end
        SPST_CLEAR:
          if (!bus.rst_i)
          begin
            next_r.cnt = 16'h0;
            next_r.st = SPST_FREE; // [R10]
          end
        default:
          next_r.st = SPST_FREE;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.st <= SPST_FREE;
      r.ua <= 1'b1;
      r.mode <= `SPS_MODE_DEFAULT;
    end
    else
      r <= next_r;
  end
endmodule

//--- sps_bus_props.sv
`timescale 1ns/1ps
`include "sps_regs.svh"
module sps_bus_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bsy_i,
  input wire logic bsy_o,
  input wire logic sel_i,
  input wire logic rst_i,
  input wire logic msg,
  input wire logic cd,
  input wire logic io,
  input wire logic req,
  input wire logic ack,
  input wire logic [7:0] db_t,
  input wire logic [7:0] db_oe
);
  localparam int CLR = `SPS_BUS_CLEAR_CYC;
  localparam int SET = `SPS_BUS_SETTLE_CYC;
  logic [7:0] idle;
  logic req_q, seen_stat, in_mi;
  wire [2:0] ph = {msg, cd, io};
  wire go = req && !req_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Saturates so a long idle bus never wraps to look busy
  always_ff @(posedge clk)
  begin
    req_q <= req;
    if (!rst_n || bsy_i || sel_i || bsy_o)
      idle <= 8'h00;
    else if (idle != 8'hff)
      idle <= idle + 8'h01;
    if (!rst_n || !bsy_o)
      seen_stat <= 1'b0;
    else if (go && ph == 3'h3)
      seen_stat <= 1'b1;
    if (!rst_n || !bsy_o)
      in_mi <= 1'b0;
    else if (go)
      in_mi <= (ph == 3'h7);
  end
  a_legal_phase: assert property (req |-> ph != 3'h4 && ph != 3'h5)
    else $error("Reserved phase code during handshake");
  a_lines_steady: assert property (req && req_q |-> $stable(ph))
    else $error("Phase lines moved during handshake");
  a_drive_dir: assert property (req |-> db_oe == (io ? 8'h00 : 8'hff))
    else $error("Data direction disagrees with io");
  a_req_stands: assert property (req && !ack && !rst_i |=> req)
    else $error("Request dropped before acknowledge");
  a_bus_clear: assert property ($rose(rst_i) |-> ##[1:CLR]
    (!req && !bsy_o && db_oe == 8'hff))
    else $error("Bus not released after reset");
  a_reset_holds: assert property (rst_i [*3] |-> !bsy_o && !req)
    else $error("Target active during bus reset");
  a_settle_free: assert property ($rose(bsy_i || sel_i) |-> idle >= SET)
    else $error("Arbitration before settle delay");
  a_one_status: assert property (go && ph == 3'h3 |-> !seen_stat)
    else $error("Second status phase in one command");
  a_no_restore: assert property (go && ph == 3'h7 && !in_mi |-> db_t != 8'h03)
    else $error("Restore pointers sent by target");
  c_data_in: cover property (go && ph == 3'h1);
  c_data_out: cover property (go && ph == 3'h0);
  c_msg_out: cover property (go && ph == 3'h6);
  c_reset: cover property ($rose(rst_i));
endmodule

//--- scsi_target_phase_sequencer_bench.sv
`timescale 1ns/1ps
module scsi_target_phase_sequencer_bench
  import sps_pkg::*;
;
  logic clk, rst_n, rv, rl, dur, blk, err, msv, start, watn, brst;
  logic [2:0] rph, cph, i_ph, ph_k;
  logic [7:0] t_tx, i_tx, msav, lf, t_rb, mode, i_rb;
  logic [31:0] dbase, act, sav;
  logic t_rdy, t_rv, atn_seen, conn, ua, resv, iop, ready, i_busy, i_rv;
  int bad_count, checks_done, cyc;
  sps_bus_if bus ();
  sps_target #(.READY_CYC(100), .POLL_CYC(50)) sps_target_inst (
    .clk(clk), .rst_n(rst_n), .bus(bus), .req_phase(rph), .req_valid(rv),
    .tx_byte(t_tx), .req_last(rl), .write_durable(dur), .block_busy(blk),
    .error(err), .mode_saved(msav), .mode_saved_valid(msv),
    .req_ready(t_rdy), .rx_valid(t_rv), .rx_byte(t_rb), .cur_phase(cph),
    .atn_seen(atn_seen), .connected(conn), .unit_attention(ua),
    .reserved(resv), .io_pending(iop), .mode(mode), .ready(ready)
  );
  sps_initiator sps_initiator_inst (
    .clk(clk), .rst_n(rst_n), .bus(bus), .start(start), .tx_byte(i_tx),
    .want_atn(watn), .bus_reset(brst), .cmd_base(32'h0000_1000),
    .data_base(dbase), .stat_base(32'h0000_3000), .busy(i_busy),
    .rx_valid(i_rv), .rx_byte(i_rb), .rx_phase(i_ph), .act_data_ptr(act),
    .sav_data_ptr(sav)
  );
  sps_bus_props sps_bus_props_inst (
    .clk(clk), .rst_n(rst_n), .bsy_i(bus.bsy_i), .bsy_o(bus.bsy_o),
    .sel_i(bus.sel_i), .rst_i(bus.rst_i), .msg(bus.msg), .cd(bus.cd),
    .io(bus.io), .req(bus.req), .ack(bus.ack), .db_t(bus.db_t),
    .db_oe(bus.db_oe)
  );
  function logic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task xfer(input logic [2:0] ph, input logic [7:0] b, input logic take);
    int n;
    @(posedge clk);
    rph <= ph;
    t_tx <= b;
    rv <= 1'b1;
    n = 0;
    while (t_rdy !== 1'b1 && n < 30)
    begin
      @(posedge clk);
      n++;
    end
    chk(t_rdy, take);
    rv <= 1'b0;
    n = 0;
    // Refused requests never move a byte, so skip the wait
    while (take && (ph[0] ? i_rv : t_rv) !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    if (take && ph[0])
    begin
      chk(i_rb, b);
      chk(i_ph, ph);
    end
    else if (take)
      chk(t_rb, i_tx);
    if (take)
      chk(cph, ph);
    repeat (4) @(posedge clk);
  endtask
  task connect;
    int n;
    start <= 1'b1;
    n = 0;
    while (conn !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    start <= 1'b0;
    chk(conn, 1'b1);
    chk(i_busy, 1'b1);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  initial
  begin
    {rst_n, rv, rl, blk, err, msv, start, watn, brst} = '0;
    dur = 1'b1;
    rph = 3'h0;
    {t_tx, i_tx, msav} = '0;
    lf = 8'h38;
    dbase = 32'h0000_2000;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(ua, 1'b1);
    chk(ready, 1'b0);
    repeat (120) @(posedge clk);
    chk(ready, 1'b1);
    connect();
    chk(act, dbase);
    i_tx <= rnd();
    xfer(3'h2, 8'h00, 1'b1);
    for (int k = 0; k < 8; k++)
    begin
      i_tx <= rnd();
      ph_k = {2'b00, lf[2]};
      xfer(ph_k, rnd(), 1'b1);
    end
    xfer(3'h4, 8'h00, 1'b0);
    xfer(3'h5, 8'h00, 1'b0);
    dur <= 1'b0;
    xfer(3'h3, 8'h00, 1'b0);
    dur <= 1'b1;
    xfer(3'h3, 8'h00, 1'b1);
    xfer(3'h3, 8'h00, 1'b0);
    rl <= 1'b1;
    xfer(3'h7, 8'h03, 1'b0);
    xfer(3'h7, 8'h02, 1'b1);
    rl <= 1'b0;
    repeat (20) @(posedge clk);
    chk(sav, dbase + 32'h8);
    chk(act, dbase + 32'h8);
    chk(conn, 1'b0);
    chk(ua, 1'b0);
    connect();
    chk(act, dbase);
    // One-cycle ATN pulse; the target must collect it in Message Out
    i_tx <= rnd();
    watn <= 1'b1;
    @(posedge clk);
    watn <= 1'b0;
    repeat (12) @(posedge clk);
    chk(i_ph, 3'h6);
    chk(t_rb, i_tx);
    chk(atn_seen, 1'b0);
    i_tx <= rnd();
    xfer(3'h6, 8'h00, 1'b1);
    msav <= rnd() | 8'h01;
    msv <= 1'b1;
    blk <= 1'b1;
    brst <= 1'b1;
    repeat (5) @(posedge clk);
    brst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(conn, 1'b0);
    chk(mode, 8'h00);
    blk <= 1'b0;
    repeat (6) @(posedge clk);
    chk(mode, msav);
    chk(ua, 1'b1);
    chk(iop, 1'b0);
    chk(resv, 1'b0);
    wrap_up();
  end
endmodule
